// file: pp_lsa_pkg.sv
/*
 * Constants, opcodes and enumerations for the peripheral processor
 * load, store and add unit.
 * Assumes a 12-bit processor memory word and an 18-bit accumulator.
 */
`default_nettype none

package pp_lsa_pkg;

    localparam int WORD_W   = 12;
    localparam int ACC_W    = 18;
    localparam int D_W      = 6;
    localparam int OPC_W    = 6;
    localparam int REL_W    = 22;
    localparam int REL_HI_W = 10;

    // Field positions inside an instruction word.
    localparam int OPC_LSB  = 6;
    localparam int D_LSB    = 0;
    localparam int ZERO_LSB = 12;

    // Reset values.
    localparam logic [ACC_W-1:0]  ACC_RST  = 18'h00000;
    localparam logic [REL_W-1:0]  REL_RST  = 22'h000000;
    localparam logic [WORD_W-1:0] WORD_RST = 12'h000;

    // Opcodes, two octal digits each.
    localparam logic [5:0] OP_LOAD_SHORT_IMMEDIATE = 6'h0C; // 14
    localparam logic [5:0] OP_LOAD_COMPLEMENTED_IMMEDIATE = 6'h0D; // 15
    localparam logic [5:0] OP_SUM_SHORT_IMMEDIATE  = 6'h0E; // 16
    localparam logic [5:0] OP_MINUS_SHORT_IMMEDIATE = 6'h0F; // 17
    localparam logic [5:0] OP_LOAD_LONG_IMMEDIATE  = 6'h10; // 20
    localparam logic [5:0] OP_SUM_LONG_IMMEDIATE   = 6'h11; // 21
    localparam logic [5:0] OP_LOAD_RELOCATION      = 6'h14; // 24
    localparam logic [5:0] OP_SAVE_RELOCATION      = 6'h15; // 25
    localparam logic [5:0] OP_LOAD_DIRECT          = 6'h18; // 30
    localparam logic [5:0] OP_SUM_DIRECT           = 6'h19; // 31
    localparam logic [5:0] OP_MINUS_DIRECT         = 6'h1A; // 32
    localparam logic [5:0] OP_WRITE_DIRECT         = 6'h1C; // 34
    localparam logic [5:0] OP_LOAD_INDIRECT        = 6'h20; // 40
    localparam logic [5:0] OP_SUM_INDIRECT         = 6'h21; // 41
    localparam logic [5:0] OP_MINUS_INDIRECT       = 6'h22; // 42
    localparam logic [5:0] OP_WRITE_INDIRECT       = 6'h24; // 44
    localparam logic [5:0] OP_LOAD_INDEXED         = 6'h28; // 50
    localparam logic [5:0] OP_SUM_INDEXED          = 6'h29; // 51
    localparam logic [5:0] OP_MINUS_INDEXED        = 6'h2A; // 52
    localparam logic [5:0] OP_WRITE_INDEXED        = 6'h2C; // 54

    typedef enum logic [2:0] {
        AM_BAD  = 3'b000,
        AM_IMM  = 3'b001,
        AM_LONG = 3'b010,
        AM_DIR  = 3'b011,
        AM_IND  = 3'b100,
        AM_IDX  = 3'b101,
        AM_REL  = 3'b110
    } amode_t;

    typedef enum logic [2:0] {
        ALU_NONE  = 3'b000,
        ALU_LOAD  = 3'b001,
        ALU_LOADC = 3'b010,
        ALU_ADD   = 3'b011,
        ALU_SUB   = 3'b100,
        ALU_STORE = 3'b101
    } alu_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RD_M  = 3'b001,
        ST_RD_D  = 3'b010,
        ST_RD_D1 = 3'b011,
        ST_RD_OP = 3'b100,
        ST_WR    = 3'b101,
        ST_WR_D1 = 3'b110
    } ctl_state_t;

endpackage

`default_nettype wire

// file: pp_load_store_add_unit.sv
/*
 * Load, store and add/subtract execution unit of a peripheral processor:
 * accumulator, relocation register and the memory sequencing they need.
 * Assumes the core hands over one instruction word with a start pulse
 * and a memory that answers each request with an acknowledge, read data
 * valid in the acknowledge cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module pp_load_store_add_unit
    import pp_lsa_pkg::*;
#(
    parameter int MEM_W = WORD_W
)
(
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               start,
    input  wire logic [15:0]        instr,
    input  wire logic [WORD_W-1:0]  p_addr,
    input  wire logic               acc_wr_en,
    input  wire logic [ACC_W-1:0]   acc_wr_data,
    output logic                    busy,
    output logic                    done,
    output logic                    bad_op,
    output logic [ACC_W-1:0]        acc,
    output logic [27:0]             reloc,
    output logic                    mem_req,
    output logic                    mem_we,
    output logic [WORD_W-1:0]       mem_addr,
    output logic [WORD_W-1:0]       mem_wdata,
    input  wire logic [WORD_W-1:0]  mem_rdata,
    input  wire logic               mem_ack
);

    // The datapath widths are tied to the instruction format.
    if (MEM_W != WORD_W) begin : g_width_check
        $error("pp_load_store_add_unit: MEM_W must equal 12");
    end

    ctl_state_t         state_q;
    ctl_state_t         state_d;
    logic [11:0]        instr_q;
    logic [11:0]        instr_d;
    logic [ACC_W-1:0]   acc_q;
    logic [ACC_W-1:0]   acc_d;
    logic [REL_W-1:0]   rel_q;
    logic [REL_W-1:0]   rel_d;
    logic [WORD_W-1:0]  m_q;
    logic [WORD_W-1:0]  m_d;
    logic [WORD_W-1:0]  addr_q;
    logic [WORD_W-1:0]  addr_d;
    logic [WORD_W-1:0]  wdata_q;
    logic [WORD_W-1:0]  wdata_d;
    logic               done_q;
    logic               done_d;
    logic               bad_q;
    logic               bad_d;

    logic [OPC_W-1:0]   cur_op;
    logic [D_W-1:0]     cur_d;
    amode_t             cur_mode;
    alu_op_t            cur_alu;
    logic [WORD_W-1:0]  d_addr;

    // Addressing mode of an opcode.
    function automatic amode_t op_mode(input logic [OPC_W-1:0] op);
        amode_t r;
        r = AM_BAD;
        case (op)
            OP_LOAD_SHORT_IMMEDIATE,
            OP_LOAD_COMPLEMENTED_IMMEDIATE,
            OP_SUM_SHORT_IMMEDIATE,
            OP_MINUS_SHORT_IMMEDIATE:       r = AM_IMM;
            OP_LOAD_LONG_IMMEDIATE,
            OP_SUM_LONG_IMMEDIATE:          r = AM_LONG;
            OP_LOAD_RELOCATION,
            OP_SAVE_RELOCATION:             r = AM_REL;
            OP_LOAD_DIRECT,
            OP_SUM_DIRECT,
            OP_MINUS_DIRECT,
            OP_WRITE_DIRECT:                r = AM_DIR;
            OP_LOAD_INDIRECT,
            OP_SUM_INDIRECT,
            OP_MINUS_INDIRECT,
            OP_WRITE_INDIRECT:              r = AM_IND;
            OP_LOAD_INDEXED,
            OP_SUM_INDEXED,
            OP_MINUS_INDEXED,
            OP_WRITE_INDEXED:               r = AM_IDX;
            default:                        r = AM_BAD;
        endcase
        return r;
    endfunction

    // Accumulator operation of an opcode.
    function automatic alu_op_t op_alu(input logic [OPC_W-1:0] op);
        alu_op_t r;
        r = ALU_NONE;
        case (op)
            OP_LOAD_SHORT_IMMEDIATE,
            OP_LOAD_LONG_IMMEDIATE,
            OP_LOAD_DIRECT,
            OP_LOAD_INDIRECT,
            OP_LOAD_INDEXED:                r = ALU_LOAD;
            OP_LOAD_COMPLEMENTED_IMMEDIATE: r = ALU_LOADC;
            OP_SUM_SHORT_IMMEDIATE,
            OP_SUM_LONG_IMMEDIATE,
            OP_SUM_DIRECT,
            OP_SUM_INDIRECT,
            OP_SUM_INDEXED:                 r = ALU_ADD;
            OP_MINUS_SHORT_IMMEDIATE,
            OP_MINUS_DIRECT,
            OP_MINUS_INDIRECT,
            OP_MINUS_INDEXED:               r = ALU_SUB;
            OP_WRITE_DIRECT,
            OP_WRITE_INDIRECT,
            OP_WRITE_INDEXED,
            OP_SAVE_RELOCATION:             r = ALU_STORE;
            default:                        r = ALU_NONE;
        endcase
        return r;
    endfunction

    // One's-complement sum with end-around carry.
    function automatic logic [ACC_W-1:0] oc_add(
        input logic [ACC_W-1:0] a,
        input logic [ACC_W-1:0] b
    );
        logic [ACC_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[ACC_W-1:0] + {{(ACC_W-1){1'b0}}, s[ACC_W]};
    endfunction

    // New accumulator value; every operand arrives already extended.
    function automatic logic [ACC_W-1:0] alu(
        input alu_op_t          k,
        input logic [ACC_W-1:0] a,
        input logic [ACC_W-1:0] b
    );
        logic [ACC_W-1:0] r;
        r = a;
        case (k)
            ALU_LOAD:  r = b;
            ALU_LOADC: r = ~b;
            ALU_ADD:   r = oc_add(a, b);
            ALU_SUB:   r = oc_add(a, ~b);
            default:   r = a;
        endcase
        return r;
    endfunction

    // The upper four bits are ignored; software keeps them clear.
    assign cur_op   = (state_q == ST_IDLE) ? instr[11:OPC_LSB]
                                           : instr_q[11:OPC_LSB];
    assign cur_d    = (state_q == ST_IDLE) ? instr[D_W-1:D_LSB]
                                           : instr_q[D_W-1:D_LSB];
    assign cur_mode = op_mode(cur_op);
    assign cur_alu  = op_alu(cur_op);
    assign d_addr   = {{(WORD_W-D_W){1'b0}}, cur_d};

    always_comb
    begin
        state_d = state_q;
        instr_d = instr_q;
        acc_d   = acc_q;
        rel_d   = rel_q;
        m_d     = m_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        done_d  = 1'b0;
        bad_d   = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (acc_wr_en)
                begin
                    acc_d = acc_wr_data;
                end
                if (start)
                begin
                    instr_d = instr[11:0];
                    wdata_d = acc_q[WORD_W-1:0];
                    case (cur_mode)
                        AM_IMM:
                        begin
                            acc_d  = alu(cur_alu, acc_q,
                                         {{(ACC_W-D_W){1'b0}}, cur_d});
                            done_d = 1'b1;
                        end
                        AM_LONG, AM_IDX:
                        begin
                            addr_d  = p_addr + 12'h001;
                            state_d = ST_RD_M;
                        end
                        AM_DIR:
                        begin
                            addr_d  = d_addr;
                            state_d = (cur_alu == ALU_STORE) ? ST_WR
                                                             : ST_RD_OP;
                        end
                        AM_IND:
                        begin
                            addr_d  = d_addr;
                            state_d = ST_RD_D;
                        end
                        AM_REL:
                        begin
                            // A zero d turns both relocation moves into a pass.
                            if (cur_d == 6'h00)
                            begin
                                done_d = 1'b1;
                            end
                            else if (cur_alu == ALU_STORE)
                            begin
                                addr_d  = d_addr;
                                wdata_d = {2'h0, rel_q[REL_W-1:WORD_W]};
                                state_d = ST_WR;
                            end
                            else
                            begin
                                addr_d  = d_addr;
                                state_d = ST_RD_D;
                            end
                        end
                        default:
                        begin
                            done_d = 1'b1;
                            bad_d  = 1'b1;
                        end
                    endcase
                end
            end
            ST_RD_M:
            begin
                if (mem_ack)
                begin
                    m_d = mem_rdata;
                    if (cur_mode == AM_LONG)
                    begin
                        acc_d   = alu(cur_alu, acc_q,
                                      {cur_d, mem_rdata});
                        done_d  = 1'b1;
                        state_d = ST_IDLE;
                    end
                    else if (cur_d == 6'h00)
                    begin
                        addr_d  = mem_rdata;
                        state_d = (cur_alu == ALU_STORE) ? ST_WR : ST_RD_OP;
                    end
                    else
                    begin
                        addr_d  = d_addr;
                        state_d = ST_RD_D;
                    end
                end
            end
            ST_RD_D:
            begin
                if (mem_ack)
                begin
                    case (cur_mode)
                        AM_REL:
                        begin
                            rel_d[REL_W-1:WORD_W] =
                                mem_rdata[REL_HI_W-1:0];
                            addr_d  = addr_q + 12'h001;
                            state_d = ST_RD_D1;
                        end
                        AM_IDX:
                        begin
                            // The index sum wraps within the memory space.
                            addr_d  = m_q + mem_rdata;
                            state_d = (cur_alu == ALU_STORE) ? ST_WR
                                                             : ST_RD_OP;
                        end
                        default:
                        begin
                            addr_d  = mem_rdata;
                            state_d = (cur_alu == ALU_STORE) ? ST_WR
                                                             : ST_RD_OP;
                        end
                    endcase
                end
            end
            ST_RD_D1:
            begin
                if (mem_ack)
                begin
                    rel_d[WORD_W-1:0] = mem_rdata;
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_RD_OP:
            begin
                if (mem_ack)
                begin
                    acc_d   = alu(cur_alu, acc_q,
                                  {{(ACC_W-WORD_W){1'b0}}, mem_rdata});
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_WR:
            begin
                if (mem_ack)
                begin
                    if (cur_mode == AM_REL)
                    begin
                        addr_d  = addr_q + 12'h001;
                        wdata_d = rel_q[WORD_W-1:0];
                        state_d = ST_WR_D1;
                    end
                    else
                    begin
                        done_d  = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_WR_D1:
            begin
                if (mem_ack)
                begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            instr_q <= WORD_RST;
            done_q  <= 1'b0;
            bad_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            instr_q <= instr_d;
            done_q  <= done_d;
            bad_q   <= bad_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            acc_q <= ACC_RST;
            rel_q <= REL_RST;
        end
        else
        begin
            acc_q <= acc_d;
            rel_q <= rel_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            m_q     <= WORD_RST;
            addr_q  <= WORD_RST;
            wdata_q <= WORD_RST;
        end
        else
        begin
            m_q     <= m_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    assign busy      = (state_q != ST_IDLE);
    assign mem_req   = (state_q != ST_IDLE);
    assign mem_we    = (state_q == ST_WR) || (state_q == ST_WR_D1);
    assign mem_addr  = addr_q;
    assign mem_wdata = wdata_q;
    assign done      = done_q;
    assign bad_op    = bad_q;
    assign acc       = acc_q;
    assign reloc     = {rel_q, 6'h00};

endmodule // pp_load_store_add_unit

`default_nettype wire

// file: pp_lsa_chk.sv
/* Concurrent checks for the load, store and add unit.
   Assumes it is bound to the unit and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none

module pp_lsa_chk
    import pp_lsa_pkg::*;
#(
    parameter int MEM_W = WORD_W
)
(
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire logic              start,
    input wire logic [15:0]       instr,
    input wire logic [WORD_W-1:0] p_addr,
    input wire logic              acc_wr_en,
    input wire logic [ACC_W-1:0]  acc_wr_data,
    input wire logic              busy,
    input wire logic              done,
    input wire logic              bad_op,
    input wire logic [ACC_W-1:0]  acc,
    input wire logic [27:0]       reloc,
    input wire logic              mem_req,
    input wire logic              mem_we,
    input wire logic [WORD_W-1:0] mem_addr,
    input wire logic [WORD_W-1:0] mem_wdata,
    input wire logic [WORD_W-1:0] mem_rdata,
    input wire logic              mem_ack
);
    logic       go;
    logic [5:0] opc;
    logic       pass_rel;

    assign go       = start && !busy;
    assign opc      = instr[11:6];
    assign pass_rel = instr[5:0] == 6'h00 &&
        (opc == OP_LOAD_RELOCATION || opc == OP_SAVE_RELOCATION);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_short_load;
        go && opc == OP_LOAD_SHORT_IMMEDIATE |=>
            done && acc == {12'h000, $past(instr[5:0])};
    endproperty
    a_short_load: assert property (p_short_load)
        else $error("short immediate load wrong");

    property p_comp_load;
        go && opc == OP_LOAD_COMPLEMENTED_IMMEDIATE |=>
            done && acc == {12'hFFF, ~$past(instr[5:0])};
    endproperty
    a_comp_load: assert property (p_comp_load)
        else $error("complemented load wrong");

    property p_direct_addr;
        go && opc == OP_LOAD_DIRECT |=>
            mem_req && !mem_we && mem_addr == {6'h00, $past(instr[5:0])};
    endproperty
    a_direct_addr: assert property (p_direct_addr)
        else $error("direct read address wrong");

    property p_write_direct;
        go && opc == OP_WRITE_DIRECT |=>
            mem_req && mem_we && mem_wdata == $past(acc[11:0]);
    endproperty
    a_write_direct: assert property (p_write_direct)
        else $error("direct write data wrong");

    property p_next_word;
        go && (opc == OP_LOAD_LONG_IMMEDIATE || opc == OP_SUM_LONG_IMMEDIATE)
            |=> mem_req && mem_addr == $past(p_addr) + 12'h001;
    endproperty
    a_next_word: assert property (p_next_word)
        else $error("second word address wrong");

    property p_rel_pass;
        go && pass_rel |=> done && !mem_req && $stable(reloc);
    endproperty
    a_rel_pass: assert property (p_rel_pass)
        else $error("relocation pass touched state");

    property p_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
            $stable(mem_we) && $stable(mem_wdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("request changed before acknowledge");

    property p_bad_done;
        bad_op |-> done;
    endproperty
    a_bad_done: assert property (p_bad_done)
        else $error("bad opcode flag without done");

    property p_done_bound;
        go |-> ##[1:64] done;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("instruction never completed");

    property p_store_acc;
        mem_req && mem_we && mem_ack |=> $stable(acc);
    endproperty
    a_store_acc: assert property (p_store_acc)
        else $error("store changed accumulator");

    property p_reloc_low;
        reloc[5:0] == 6'h00;
    endproperty
    a_reloc_low: assert property (p_reloc_low)
        else $error("relocation low bits not zero");
endmodule // pp_lsa_chk

bind pp_load_store_add_unit pp_lsa_chk #(.MEM_W(MEM_W)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .start(start), .instr(instr),
    .p_addr(p_addr), .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
    .busy(busy), .done(done), .bad_op(bad_op), .acc(acc), .reloc(reloc),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
);

`default_nettype wire

// file: ppm_model.sv
/* Processor memory model: 4096 words answered by an acknowledge.
   Assumes one request at a time held until its acknowledge. */
`timescale 1ns/1ps
`default_nettype none

module ppm_model
    import pp_lsa_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [1:0]        waits,
    input  wire logic              mem_req,
    input  wire logic              mem_we,
    input  wire logic [WORD_W-1:0] mem_addr,
    input  wire logic [WORD_W-1:0] mem_wdata,
    output logic      [WORD_W-1:0] mem_rdata,
    output logic                   mem_ack
);
    logic [WORD_W-1:0] words [0:4095];
    logic [1:0]        wait_q;

    initial
    begin
        for (int i = 0; i < 4096; i++)
            words[i] = 12'h000;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst || !mem_req || mem_ack)
        begin
            mem_ack <= 1'b0;
            wait_q  <= 2'h0;
        end
        else if (wait_q == waits)
            mem_ack <= 1'b1;
        else
            wait_q <= wait_q + 2'h1;
    end

    always @(posedge mclk)
    begin
        if (mem_req && mem_ack && mem_we)
            words[mem_addr] <= mem_wdata;
    end

    // Outside an acknowledge the data bus shows garbage, never old data.
    assign mem_rdata = mem_ack ? words[mem_addr] : ~words[mem_addr];
endmodule // ppm_model

`default_nettype wire

// file: pp_load_store_add_unit_tb.sv
/* Self-checking bench for the load, store and add unit.
   Assumes the memory model and the bound checker beside it. */
`timescale 1ns/1ps
`default_nettype none

module pp_load_store_add_unit_tb
    import pp_lsa_pkg::*;
;
    localparam logic [17:0] A0 = 18'h12345;
    localparam logic [11:0] P  = 12'h100;
    localparam logic [5:0]  BASE [4] = '{6'h18, 6'h20, 6'h28, 6'h28};
    localparam logic [5:0]  DSEL [4] = '{6'h07, 6'h05, 6'h05, 6'h00};
    localparam logic [11:0] OPND [4] = '{12'h0F1, 12'h0AB, 12'h3C4, 12'h555};
    localparam logic [11:0] TGT  [4] = '{12'h007, 12'h010, 12'h210, 12'h200};

    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        start = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [11:0] p_addr = 12'h000;
    logic        acc_wr_en = 1'b0;
    logic [17:0] acc_wr_data = 18'h00000;
    logic [1:0]  mem_wait = 2'h0;
    logic        busy, done, bad_op, mem_req, mem_we, mem_ack;
    logic [17:0] acc;
    logic [27:0] reloc;
    logic [11:0] mem_addr, mem_wdata, mem_rdata;
    int          errors = 0;
    int          checked = 0;

    always #20 mclk = ~mclk;

    pp_load_store_add_unit DUT (
        .mclk(mclk), .sys_rst(sys_rst), .start(start), .instr(instr),
        .p_addr(p_addr), .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
        .busy(busy), .done(done), .bad_op(bad_op), .acc(acc), .reloc(reloc),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    ppm_model mem (
        .mclk(mclk), .sys_rst(sys_rst), .waits(mem_wait),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    // End-around carry makes the sum one's complement.
    function automatic logic [17:0] oc_add(input logic [17:0] a,
                                           input logic [17:0] b);
        logic [18:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[17:0] + {17'h00000, s[18]};
    endfunction

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic preload(input logic [17:0] v);
        acc_wr_en = 1'b1;
        acc_wr_data = v;
        @(posedge mclk);
        #1 acc_wr_en = 1'b0;
    endtask

    task automatic run(input logic [5:0] op, input logic [5:0] d,
                       input logic [11:0] p, input logic [17:0] exp);
        int n;
        n = 0;
        instr = {4'h0, op, d};
        p_addr = p;
        start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        while (done !== 1'b1 && n < 60)
        begin
            @(posedge mclk);
            #1 n++;
        end
        check(done === 1'b1, "no done");
        check(acc === exp, "accumulator mismatch");
        check(bad_op === (op == 6'h3F || op == 6'h13), "bad flag");
    endtask

    task automatic s_immediate();
        preload(A0);
        run(6'h0C, 6'h3F, P, {12'h000, 6'h3F});
        run(6'h0D, 6'h05, P, {12'hFFF, 6'h3A});
        preload(A0);
        run(6'h0E, 6'h3F, P, oc_add(A0, 18'h0003F));
        preload(A0);
        run(6'h0F, 6'h3F, P, oc_add(A0, 18'h3FFC0));
        preload(18'h00000);
        run(6'h0F, 6'h00, P, 18'h3FFFF);
    endtask

    task automatic s_modes();
        logic [17:0] w;
        mem.words[12'h101] = 12'h200;
        mem.words[12'h007] = 12'h0F1;
        mem.words[12'h005] = 12'h010;
        mem.words[12'h010] = 12'h0AB;
        mem.words[12'h210] = 12'h3C4;
        mem.words[12'h200] = 12'h555;
        mem.words[12'h000] = 12'h777;
        for (int k = 0; k < 4; k++)
        begin
            mem_wait = k[1:0];
            w = {6'h00, OPND[k]};
            preload(A0);
            run(BASE[k], DSEL[k], P, w);
            preload(A0);
            run(BASE[k] + 6'h01, DSEL[k], P, oc_add(A0, w));
            preload(A0);
            run(BASE[k] + 6'h02, DSEL[k], P, oc_add(A0, ~w));
            preload(A0);
            run(BASE[k] + 6'h04, DSEL[k], P, A0);
            check(mem.words[TGT[k]] === A0[11:0], "stored word");
        end
    endtask

    task automatic s_long();
        preload(A0);
        run(6'h10, 6'h2A, P, {6'h2A, 12'h200});
        preload(A0);
        run(6'h11, 6'h2A, 12'hFFF, oc_add(A0, {6'h2A, 12'h777}));
    endtask

    task automatic s_reloc();
        mem.words[12'h021] = 12'hABC;
        mem.words[12'h022] = 12'h123;
        mem.words[12'h001] = 12'h000;
        preload(A0);
        run(6'h14, 6'h21, P, A0);
        check(reloc === {10'h2BC, 12'h123, 6'h00}, "reloc load");
        run(6'h15, 6'h30, P, A0);
        check(mem.words[12'h030] === 12'h2BC, "reloc save hi");
        check(mem.words[12'h031] === 12'h123, "reloc save lo");
        run(6'h14, 6'h00, P, A0);
        check(reloc === {10'h2BC, 12'h123, 6'h00}, "reloc pass");
        run(6'h15, 6'h00, P, A0);
        check(mem.words[12'h000] === 12'h777, "save pass");
        run(6'h13, 6'h01, P, A0);
        run(6'h3F, 6'h01, P, A0);
    endtask

    task automatic stop_test();
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #800000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        #1 sys_rst = 1'b0;
        @(posedge mclk);
        #1 check(acc === ACC_RST && reloc === 28'h0000000, "reset");
        s_immediate();
        s_modes();
        s_long();
        s_reloc();
        stop_test();
    end
endmodule // pp_load_store_add_unit_tb

`default_nettype wire
